// file: hdl/_unused_marker_do_not_compile.sv
`default_nettype none
`default_nettype wire

// file: hdl/lpci_afifo.sv
// Dual clock FIFO with gray coded pointers
`default_nettype none

module lpci_afifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             wr_clk_i,
	input  wire logic             wr_rst_i,
	input  wire logic             wr_valid_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  wr_ready_o,
	input  wire logic             rd_clk_i,
	input  wire logic             rd_rst_i,
	input  wire logic             rd_ready_i,
	output logic                  rd_valid_o,
	output logic      [WIDTH-1:0] rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	// Gray full test needs a power of two and at least two address bits
	if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("lpci_afifo: DEPTH must be a power of two, 4 or more");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin_r;
	logic [AW:0]      wgray_r;
	logic [AW:0]      rbin_r;
	logic [AW:0]      rgray_r;
	logic [AW:0]      rq1_r;
	logic [AW:0]      rq2_r;
	logic [AW:0]      wq1_r;
	logic [AW:0]      wq2_r;

	// ****************************************************************
	// Write side
	// ****************************************************************
	wire          w_fire    = wr_valid_i & wr_ready_o;
	wire [AW:0]   wbin_nxt  = wbin_r + {{AW{1'b0}}, w_fire};
	wire [AW:0]   wgray_nxt = (wbin_nxt >> 1) ^ wbin_nxt;
	wire          full_nxt  = wgray_nxt == {~rq2_r[AW:AW-1], rq2_r[AW-2:0]};

	// Full is registered so the ready stays glitch free
	always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
		if (wr_rst_i) begin
			wbin_r     <= '0;
			wgray_r    <= '0;
			rq1_r      <= '0;
			rq2_r      <= '0;
			wr_ready_o <= 1'b1;
		end else begin
			wbin_r     <= wbin_nxt;
			wgray_r    <= wgray_nxt;
			rq1_r      <= rgray_r;
			rq2_r      <= rq1_r;
			wr_ready_o <= ~full_nxt;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge wr_clk_i) begin
		if (w_fire) begin
			mem[wbin_r[AW-1:0]] <= wr_data_i;
		end
	end

	// ****************************************************************
	// Read side
	// ****************************************************************
	wire          r_fire    = rd_valid_o & rd_ready_i;
	wire [AW:0]   rbin_nxt  = rbin_r + {{AW{1'b0}}, r_fire};
	wire [AW:0]   rgray_nxt = (rbin_nxt >> 1) ^ rbin_nxt;
	wire          empty_nxt = rgray_nxt == wq2_r;

	// Empty is registered as well
	always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
		if (rd_rst_i) begin
			rbin_r     <= '0;
			rgray_r    <= '0;
			wq1_r      <= '0;
			wq2_r      <= '0;
			rd_valid_o <= 1'b0;
		end else begin
			rbin_r     <= rbin_nxt;
			rgray_r    <= rgray_nxt;
			wq1_r      <= wgray_r;
			wq2_r      <= wq1_r;
			rd_valid_o <= ~empty_nxt;
		end
	end

	assign rd_data_o = mem[rbin_r[AW-1:0]];
endmodule

`default_nettype wire

// file: hdl/lpci_pin_if.sv
// Multi channel memory pin interface: sequencing, command and data engine
`include "lpci_defs.svh"
`default_nettype none

module lpci_pin_if
	import lpci_pkg::*;
#(
	parameter int NUM_CHAN      = `LPCI_NUM_CHAN,
	parameter int LANES         = `LPCI_LANES,
	parameter int LANE_BITS     = `LPCI_LANE_BITS,
	parameter int RANKS         = `LPCI_RANKS,
	parameter int CA_BITS       = `LPCI_CA_BITS,
	parameter int FIFO_DEPTH    = `LPCI_FIFO_DEPTH,
	parameter int READ_WAIT_CYC = `LPCI_READ_WAIT_CYC,
	parameter int RST_HOLD_CYC  = `LPCI_CYC_UP(`LPCI_RST_HOLD_NS)
) (
	input  wire logic                              CORE_CLK_I,
	input  wire logic                              RESET_I,
	input  wire logic                              LINK_CLK_I,
	input  wire logic                              POWER_GOOD_I,
	input  wire logic                              SUSPEND_TO_RAM_I,
	input  wire logic [RANKS-1:0]                  POWER_DOWN_RANK_I,
	input  wire logic                              CMD_VALID_I,
	output logic                                   CMD_READY_O,
	input  wire logic                              CMD_WRITE_I,
	input  wire logic [RANKS-1:0]                  CMD_RANK_SEL_I,
	input  wire logic [NUM_CHAN-1:0]               CMD_CHAN_SEL_I,
	input  wire logic [CA_BITS-1:0]                CMD_CA_FIRST_I,
	input  wire logic [CA_BITS-1:0]                CMD_CA_SECOND_I,
	input  wire logic [NUM_CHAN*LANES*LANE_BITS-1:0] CMD_WDATA_I,
	output logic                                   RD_VALID_O,
	input  wire logic                              RD_READY_I,
	output logic [NUM_CHAN*LANES*LANE_BITS-1:0]    RD_DATA_O,
	output logic                                   RD_TIMEOUT_O,
	output logic                                   MEM_RESET_N_O,
	output logic [NUM_CHAN-1:0]                    MEM_CLOCK_TRUE_O,
	output logic [NUM_CHAN-1:0]                    MEM_CLOCK_COMP_O,
	output logic [NUM_CHAN*RANKS-1:0]              RANK_CLOCK_ENABLE_O,
	output logic [NUM_CHAN*RANKS-1:0]              RANK_SELECT_O,
	output logic [NUM_CHAN*CA_BITS-1:0]            CMD_ADDR_BUS_O,
	input  wire logic [NUM_CHAN*LANES*LANE_BITS-1:0] DATA_LANES_I,
	output logic [NUM_CHAN*LANES*LANE_BITS-1:0]    DATA_LANES_O,
	output logic [NUM_CHAN*LANES-1:0]              DATA_LANES_OE_O,
	input  wire logic [NUM_CHAN*LANES-1:0]         STROBE_TRUE_I,
	output logic [NUM_CHAN*LANES-1:0]              STROBE_TRUE_O,
	input  wire logic [NUM_CHAN*LANES-1:0]         STROBE_COMP_I,
	output logic [NUM_CHAN*LANES-1:0]              STROBE_COMP_O,
	output logic [NUM_CHAN*LANES-1:0]              STROBE_OE_O
);
	localparam int CNT_W    = `LPCI_CNT_W;
	localparam int NL       = NUM_CHAN * LANES;
	localparam int DW       = NL * LANE_BITS;
	localparam int CW       = NUM_CHAN * RANKS;
	localparam int WW       = 1 + RANKS + NUM_CHAN + 2 * CA_BITS + DW;
	localparam int CKE_CYC  = `LPCI_CYC_UP(`LPCI_CKE_WAIT_NS);
	localparam int DRN_CYC  = `LPCI_CYC_UP(`LPCI_DRAIN_NS);
	localparam int RW_W     = $clog2(READ_WAIT_CYC + 1);

	// Counters must hold every wait
	if (RST_HOLD_CYC < 1 || RST_HOLD_CYC >= (1 << CNT_W) || READ_WAIT_CYC < 2 ||
	    NUM_CHAN < 1 || LANES < 1 || RANKS < 1) begin : g_bad_param
		$error("lpci_pin_if: parameter out of range");
	end

	// ****************************************************************
	// System side sequencer
	// ****************************************************************
	lpci_ctl_e          ctl_r;
	lpci_ctl_e          ctl_nxt;
	logic [CNT_W-1:0]   cnt_r;
	logic [CNT_W-1:0]   cnt_nxt;
	logic               pg_s1_r;
	logic               pg_s2_r;
	logic               idle_s1_r;
	logic               idle_s2_r;
	logic               accept_r;
	logic               link_idle_r;
	logic [RANKS-1:0]   rank_en_nxt;
	logic               cmd_wr_ready;

	wire cnt_sat  = cnt_r == {CNT_W{1'b1}};
	wire rst_done = cnt_r >= CNT_W'(RST_HOLD_CYC - 1);
	wire cke_done = cnt_r >= CNT_W'(CKE_CYC - 1);
	wire drn_done = cnt_r >= CNT_W'(DRN_CYC - 1);

	// Next state; losing power always falls back to reset
	always_comb begin
		ctl_nxt = ctl_r;
		cnt_nxt = cnt_sat ? cnt_r : cnt_r + 1'b1;
		case (ctl_r)
			CTL_RESET: begin
				if (rst_done) begin
					ctl_nxt = CTL_INIT;
					cnt_nxt = '0;
				end
			end
			CTL_INIT: begin
				if (cke_done) begin
					ctl_nxt = CTL_ACTIVE;
					cnt_nxt = '0;
				end
			end
			CTL_ACTIVE: begin
				if (SUSPEND_TO_RAM_I) begin
					ctl_nxt = CTL_DRAIN;
					cnt_nxt = '0;
				end
			end
			CTL_DRAIN: begin
				// Guard covers pointers still crossing toward the link
				if (drn_done && idle_s2_r) begin
					ctl_nxt = CTL_SELF_REF;
				end
			end
			CTL_SELF_REF: begin
				if (!SUSPEND_TO_RAM_I) begin
					ctl_nxt = CTL_EXIT;
					cnt_nxt = '0;
				end
			end
			CTL_EXIT: begin
				if (cke_done) begin
					ctl_nxt = CTL_ACTIVE;
				end
			end
			default: ctl_nxt = CTL_RESET;
		endcase
		if (!pg_s2_r) begin
			ctl_nxt = CTL_RESET;
			cnt_nxt = '0;
		end
	end

	// Clock enable per rank, same on every channel; ranks stay up while draining
	always_comb begin
		case (ctl_nxt)
			CTL_ACTIVE, CTL_DRAIN: rank_en_nxt = ~POWER_DOWN_RANK_I;
			CTL_EXIT:   rank_en_nxt = {RANKS{1'b1}};
			default:    rank_en_nxt = '0;
		endcase
	end

	// Sequencer state and pins; power good is a pin and is synchronised
	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ctl_r               <= CTL_RESET;
			cnt_r               <= '0;
			pg_s1_r             <= 1'b0;
			pg_s2_r             <= 1'b0;
			idle_s1_r           <= 1'b0;
			idle_s2_r           <= 1'b0;
			accept_r            <= 1'b0;
			MEM_RESET_N_O       <= 1'b0;
			RANK_CLOCK_ENABLE_O <= '0;
		end else begin
			ctl_r               <= ctl_nxt;
			cnt_r               <= cnt_nxt;
			pg_s1_r             <= POWER_GOOD_I;
			pg_s2_r             <= pg_s1_r;
			idle_s1_r           <= link_idle_r;
			idle_s2_r           <= idle_s1_r;
			accept_r            <= ctl_nxt == CTL_ACTIVE;
			MEM_RESET_N_O       <= ctl_nxt != CTL_RESET;
			RANK_CLOCK_ENABLE_O <= {NUM_CHAN{rank_en_nxt}};
		end
	end

	// Commands are taken only while the memories are active
	assign CMD_READY_O = cmd_wr_ready & accept_r;

	// ****************************************************************
	// Link side reset and clock pair
	// ****************************************************************
	logic lrst_s1_r;
	logic lrst_s2_r;
	logic ck_r;

	// Asynchronous assert, release aligned to the link clock
	always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			lrst_s1_r <= 1'b1;
			lrst_s2_r <= 1'b1;
		end else begin
			lrst_s1_r <= 1'b0;
			lrst_s2_r <= lrst_s1_r;
		end
	end

	// Memory clock is the link clock halved; one pair per channel
	always_ff @(posedge LINK_CLK_I or posedge lrst_s2_r) begin
		if (lrst_s2_r) begin
			ck_r             <= 1'b0;
			MEM_CLOCK_TRUE_O <= '0;
			MEM_CLOCK_COMP_O <= '1;
		end else begin
			ck_r             <= ~ck_r;
			MEM_CLOCK_TRUE_O <= {NUM_CHAN{~ck_r}};
			MEM_CLOCK_COMP_O <= {NUM_CHAN{ck_r}};
		end
	end

	// Pins change only as true falls, so each is steady at its rising edge, save the read second beat, cleared as true rises
	wire step = ck_r;

	// ****************************************************************
	// Command FIFO and link engine
	// ****************************************************************
	lpci_link_e             lk_r;
	logic                   fifo_valid;
	logic [WW-1:0]          fifo_data;
	logic                   f_wr;
	logic [RANKS-1:0]       f_rank;
	logic [NUM_CHAN-1:0]    f_chan;
	logic [CA_BITS-1:0]     f_ca0;
	logic [CA_BITS-1:0]     f_ca1;
	logic [DW-1:0]          f_data;
	logic                   cw_r;
	logic [NUM_CHAN-1:0]    cchan_r;
	logic [CA_BITS-1:0]     cca1_r;
	logic [RW_W-1:0]        wait_r;
	logic                   tmo_r;
	logic [NL-1:0]          got_r;
	logic [DW-1:0]          rdata_r;
	logic [DW-1:0]          ds1_r;
	logic [DW-1:0]          ds2_r;
	logic [NL-1:0]          ts1_r;
	logic [NL-1:0]          ts2_r;
	logic [NL-1:0]          tp_r;
	logic [NL-1:0]          cs1_r;
	logic [NL-1:0]          cs2_r;
	logic [CW-1:0]          sel_first;
	logic [NUM_CHAN*CA_BITS-1:0] ca_first;
	logic [NUM_CHAN*CA_BITS-1:0] ca_second;
	logic [NL-1:0]          lane_en;
	logic                   ret_ready;

	wire pop = step && lk_r == LNK_IDLE && fifo_valid;

	lpci_afifo #(
		.WIDTH (WW),
		.DEPTH (FIFO_DEPTH)
	) u_cmd_fifo (
		.wr_clk_i   (CORE_CLK_I),
		.wr_rst_i   (RESET_I),
		.wr_valid_i (CMD_VALID_I & accept_r),
		.wr_data_i  ({CMD_WRITE_I, CMD_RANK_SEL_I, CMD_CHAN_SEL_I, CMD_CA_FIRST_I,
		              CMD_CA_SECOND_I, CMD_WDATA_I}),
		.wr_ready_o (cmd_wr_ready),
		.rd_clk_i   (LINK_CLK_I),
		.rd_rst_i   (lrst_s2_r),
		.rd_ready_i (pop),
		.rd_valid_o (fifo_valid),
		.rd_data_o  (fifo_data)
	);

	assign {f_wr, f_rank, f_chan, f_ca0, f_ca1, f_data} = fifo_data;

	// Per channel spread of select, command beats and lane enables
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		assign sel_first[c*RANKS +: RANKS]     = f_chan[c] ? f_rank : '0;
		assign ca_first[c*CA_BITS +: CA_BITS]  = f_chan[c] ? f_ca0 : '0;
		assign ca_second[c*CA_BITS +: CA_BITS] = cchan_r[c] ? cca1_r : '0;
		assign lane_en[c*LANES +: LANES]       = {LANES{cchan_r[c]}};
	end

	// A lane strobe crossing: true rises while complement is low
	wire [NL-1:0] xing     = ts2_r & ~tp_r & ~cs2_r;
	wire          all_got  = &(got_r | ~lane_en);
	wire          wait_end = wait_r >= RW_W'(READ_WAIT_CYC - 1);

	// Read pins pass two flops before use
	always_ff @(posedge LINK_CLK_I or posedge lrst_s2_r) begin
		if (lrst_s2_r) begin
			ds1_r <= '0;
			ds2_r <= '0;
			ts1_r <= '0;
			ts2_r <= '0;
			tp_r  <= '0;
			cs1_r <= '0;
			cs2_r <= '0;
		end else begin
			ds1_r <= DATA_LANES_I;
			ds2_r <= ds1_r;
			ts1_r <= STROBE_TRUE_I;
			ts2_r <= ts1_r;
			tp_r  <= ts2_r;
			cs1_r <= STROBE_COMP_I;
			cs2_r <= cs1_r;
		end
	end

	// Engine: two command beats, then write burst or read capture
	always_ff @(posedge LINK_CLK_I or posedge lrst_s2_r) begin
		if (lrst_s2_r) begin
			lk_r            <= LNK_IDLE;
			cw_r            <= 1'b0;
			cchan_r         <= '0;
			cca1_r          <= '0;
			wait_r          <= '0;
			tmo_r           <= 1'b0;
			got_r           <= '0;
			rdata_r         <= '0;
			link_idle_r     <= 1'b0;
			RANK_SELECT_O   <= '0;
			CMD_ADDR_BUS_O  <= '0;
			DATA_LANES_O    <= '0;
			DATA_LANES_OE_O <= '0;
			STROBE_TRUE_O   <= '0;
			STROBE_COMP_O   <= '0;
			STROBE_OE_O     <= '0;
		end else begin
			link_idle_r <= lk_r == LNK_IDLE && !fifo_valid;
			case (lk_r)
				LNK_IDLE: begin
					if (pop) begin
						cw_r           <= f_wr;
						cchan_r        <= f_chan;
						cca1_r         <= f_ca1;
						DATA_LANES_O   <= f_data;
						RANK_SELECT_O  <= sel_first;
						CMD_ADDR_BUS_O <= ca_first;
						lk_r           <= LNK_CA2;
					end
				end
				LNK_CA2: begin
					if (step) begin
						RANK_SELECT_O  <= '0;
						CMD_ADDR_BUS_O <= ca_second;
						wait_r         <= '0;
						got_r          <= '0;
						if (cw_r) begin
							DATA_LANES_OE_O <= lane_en;
							STROBE_OE_O     <= lane_en;
							STROBE_TRUE_O   <= '0;
							STROBE_COMP_O   <= '1;
							lk_r            <= LNK_WPRE;
						end else begin
							lk_r <= LNK_RWAIT;
						end
					end
				end
				LNK_WPRE: begin
					if (step) begin
						CMD_ADDR_BUS_O <= '0;
						STROBE_TRUE_O  <= '1;
						STROBE_COMP_O  <= '0;
						lk_r           <= LNK_WDATA;
					end
				end
				LNK_WDATA: begin
					if (step) begin
						DATA_LANES_OE_O <= '0;
						STROBE_OE_O     <= '0;
						STROBE_TRUE_O   <= '0;
						lk_r            <= LNK_IDLE;
					end
				end
				LNK_RWAIT: begin
					// Sampled every link cycle to catch each strobe
					CMD_ADDR_BUS_O <= '0;
					wait_r         <= wait_r + 1'b1;
					for (int i = 0; i < NL; i++) begin
						if (xing[i] && lane_en[i] && !got_r[i]) begin
							rdata_r[i*LANE_BITS +: LANE_BITS] <= ds2_r[i*LANE_BITS +: LANE_BITS];
							got_r[i] <= 1'b1;
						end
					end
					if (all_got || wait_end) begin
						tmo_r <= !all_got;
						lk_r  <= LNK_RPUSH;
					end
				end
				LNK_RPUSH: begin
					// Stalls here while the return path is full
					if (ret_ready) begin
						lk_r <= LNK_IDLE;
					end
				end
				default: lk_r <= LNK_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Read return path
	// ****************************************************************
	lpci_afifo #(
		.WIDTH (DW + 1),
		.DEPTH (FIFO_DEPTH)
	) u_ret_fifo (
		.wr_clk_i   (LINK_CLK_I),
		.wr_rst_i   (lrst_s2_r),
		.wr_valid_i (lk_r == LNK_RPUSH),
		.wr_data_i  ({tmo_r, rdata_r}),
		.wr_ready_o (ret_ready),
		.rd_clk_i   (CORE_CLK_I),
		.rd_rst_i   (RESET_I),
		.rd_ready_i (RD_READY_I),
		.rd_valid_o (RD_VALID_O),
		.rd_data_o  ({RD_TIMEOUT_O, RD_DATA_O})
	);
endmodule

`default_nettype wire

// file: shared/lpci_defs.svh
// Constants for the memory channel pin interface
`ifndef LPCI_DEFS_SVH
`define LPCI_DEFS_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define LPCI_NUM_CHAN       4
`define LPCI_LANES          4
`define LPCI_LANE_BITS      8
`define LPCI_RANKS          2
`define LPCI_CA_BITS        6
`define LPCI_FIFO_DEPTH     8
`define LPCI_CNT_W          16

// ****************************************************************
// Timing
// ****************************************************************
`define LPCI_CORE_PERIOD_NS 20
`define LPCI_RST_HOLD_NS    200000
`define LPCI_CKE_WAIT_NS    2000
`define LPCI_DRAIN_NS       1280
`define LPCI_READ_WAIT_CYC  32
`define LPCI_CYC_UP(ns)     (((ns) + `LPCI_CORE_PERIOD_NS - 1) / `LPCI_CORE_PERIOD_NS)

`endif

// file: shared/lpci_pkg.sv
// Types shared by the memory channel pin interface
`default_nettype none

package lpci_pkg;
	// System side sequencing of reset, clock enables and suspend
	typedef enum logic [2:0] {
		CTL_RESET,
		CTL_INIT,
		CTL_ACTIVE,
		CTL_DRAIN,
		CTL_SELF_REF,
		CTL_EXIT
	} lpci_ctl_e;

	// Link side command and data engine
	typedef enum logic [2:0] {
		LNK_IDLE,
		LNK_CA2,
		LNK_WPRE,
		LNK_WDATA,
		LNK_RWAIT,
		LNK_RPUSH
	} lpci_link_e;
endpackage

`default_nettype wire

// file: tb/lpci_mem_model.sv
// Behavioural memory ranks on four channels, one word kept per channel
`default_nettype none

module lpci_mem_model #(
	parameter logic [5:0] RD_CODE = 6'h12
) (
	input  wire logic         link_clk_i,
	input  wire logic         slow_i,
	input  wire logic [3:0]   mem_clk_i,
	input  wire logic [7:0]   sel_i,
	input  wire logic [23:0]  ca_i,
	input  wire logic [127:0] dq_i,
	input  wire logic [15:0]  dq_oe_i,
	input  wire logic [15:0]  st_i,
	input  wire logic [15:0]  sc_i,
	input  wire logic [15:0]  s_oe_i,
	output logic      [127:0] dq_o,
	output logic      [15:0]  st_o,
	output logic      [15:0]  sc_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [4];
	logic [3:0]  drv;
	logic [3:0]  mt;
	logic [3:0]  mc;
	for (genvar c = 0; c < 4; c++) begin : g_ch
		logic [5:0] first;
		logic       armed;
		initial begin
			armed = 1'b0;
			drv[c] = 1'b0;
			mem[c] = '0;
		end
		// Beats taken at the rising true edge; slow answers exceed the read wait
		always @(posedge mem_clk_i[c]) begin
			if (|sel_i[c*2+:2]) begin
				first = ca_i[c*6+:6];
				armed = 1'b1;
			end else if (armed) begin
				armed = 1'b0;
				if (first == RD_CODE) begin
					repeat (slow_i ? 40 : 2) @(posedge link_clk_i);
					mt[c] = 1'b0;
					mc[c] = 1'b1;
					drv[c] = 1'b1;
					@(posedge link_clk_i);
					mt[c] = 1'b1;
					mc[c] = 1'b0;
					repeat (2) @(posedge link_clk_i);
					drv[c] = 1'b0;
				end
			end
		end
		// Write data taken at the strobe crossing, once both strobe pins have settled
		always @(posedge st_i[c*4]) begin
			#1;
			if (s_oe_i[c*4] && !sc_i[c*4]) mem[c] = dq_i[c*32+:32];
		end
		// Wire level: released lines show the inverse, never a stale copy
		for (genvar l = 0; l < 4; l++) begin : g_ln
			localparam int K = c*4 + l;
			assign dq_o[K*8+:8] = dq_oe_i[K] ? dq_i[K*8+:8] :
				drv[c] ? mem[c][l*8+:8] : ~dq_i[K*8+:8];
			assign st_o[K] = s_oe_i[K] ? st_i[K] : drv[c] ? mt[c] : ~st_i[K];
			assign sc_o[K] = s_oe_i[K] ? sc_i[K] : drv[c] ? mc[c] : ~sc_i[K];
		end
	end
endmodule

`default_nettype wire

// file: tb/lpci_pin_if_monitor.sv
// Pin level checks on the memory channel interface
`default_nettype none

module lpci_pin_if_monitor #(
	parameter int NUM_CHAN = 4,
	parameter int RANKS    = 2,
	parameter int LANES    = 4,
	parameter int CA_BITS  = 6
) (
	input wire logic                        CORE_CLK_I,
	input wire logic                        RESET_I,
	input wire logic                        LINK_CLK_I,
	input wire logic                        SUSPEND_TO_RAM_I,
	input wire logic [RANKS-1:0]            POWER_DOWN_RANK_I,
	input wire logic                        CMD_READY_O,
	input wire logic                        MEM_RESET_N_O,
	input wire logic [NUM_CHAN-1:0]         MEM_CLOCK_TRUE_O,
	input wire logic [NUM_CHAN-1:0]         MEM_CLOCK_COMP_O,
	input wire logic [NUM_CHAN*RANKS-1:0]   RANK_CLOCK_ENABLE_O,
	input wire logic [NUM_CHAN*RANKS-1:0]   RANK_SELECT_O,
	input wire logic [NUM_CHAN*CA_BITS-1:0] CMD_ADDR_BUS_O,
	input wire logic [NUM_CHAN*LANES-1:0]   DATA_LANES_OE_O,
	input wire logic [NUM_CHAN*LANES-1:0]   STROBE_OE_O
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Link side: clock pair, select, command beats
	// ****************************************
	clk_pair_a: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		MEM_CLOCK_COMP_O == ~MEM_CLOCK_TRUE_O && (MEM_CLOCK_TRUE_O == '0 || MEM_CLOCK_TRUE_O == '1))
		else $error("memory clock pair not complementary or not shared");
	clk_toggle_a: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		MEM_CLOCK_TRUE_O[0] |=> !MEM_CLOCK_TRUE_O[0]) else $error("memory clock stuck high");
	sel_hold_a: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		$rose(|RANK_SELECT_O) |=> $stable(RANK_SELECT_O) ##1 RANK_SELECT_O == '0)
		else $error("select not held one memory clock");
	ca_walk_a: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		$rose(|RANK_SELECT_O) |-> ##4 CMD_ADDR_BUS_O == '0) else $error("command beats mistimed");
	sel_cke_a: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		(RANK_SELECT_O & ~RANK_CLOCK_ENABLE_O) == '0) else $error("select to disabled rank");
	oe_pair_a: assert property (@(posedge LINK_CLK_I) disable iff (RESET_I)
		STROBE_OE_O == DATA_LANES_OE_O) else $error("strobe and data enables differ");
	// ****************************************
	// System side: reset, clock enables, suspend
	// ****************************************
	rst_cke_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		!MEM_RESET_N_O |-> RANK_CLOCK_ENABLE_O == '0) else $error("enable high in memory reset");
	cke_follow_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		CMD_READY_O && $past(CMD_READY_O) && $stable(POWER_DOWN_RANK_I)
		|-> RANK_CLOCK_ENABLE_O == {NUM_CHAN{~POWER_DOWN_RANK_I}}) else $error("enable mismatch");
	susp_ready_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		SUSPEND_TO_RAM_I ##1 SUSPEND_TO_RAM_I |-> !CMD_READY_O) else $error("ready in suspend");
	self_ref_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		$rose(SUSPEND_TO_RAM_I) |=> $stable(RANK_CLOCK_ENABLE_O)
		##[63:400] RANK_CLOCK_ENABLE_O == '0)
		else $error("self refresh entry missing");
	wake_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		$fell(SUSPEND_TO_RAM_I) |-> ##[1:3] RANK_CLOCK_ENABLE_O == '1)
		else $error("self refresh exit missing");
endmodule

bind lpci_pin_if lpci_pin_if_monitor #(.NUM_CHAN(NUM_CHAN), .RANKS(RANKS), .LANES(LANES),
	.CA_BITS(CA_BITS)) u_mon (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
	.LINK_CLK_I(LINK_CLK_I), .SUSPEND_TO_RAM_I(SUSPEND_TO_RAM_I),
	.POWER_DOWN_RANK_I(POWER_DOWN_RANK_I), .CMD_READY_O(CMD_READY_O),
	.MEM_RESET_N_O(MEM_RESET_N_O), .MEM_CLOCK_TRUE_O(MEM_CLOCK_TRUE_O),
	.MEM_CLOCK_COMP_O(MEM_CLOCK_COMP_O), .RANK_CLOCK_ENABLE_O(RANK_CLOCK_ENABLE_O),
	.RANK_SELECT_O(RANK_SELECT_O), .CMD_ADDR_BUS_O(CMD_ADDR_BUS_O),
	.DATA_LANES_OE_O(DATA_LANES_OE_O), .STROBE_OE_O(STROBE_OE_O));

`default_nettype wire

// file: tb/test_lpci_pin_if.sv
// Self-checking bench for the memory channel pin interface
`default_nettype none

module test_lpci_pin_if;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [5:0] WR = 6'h11;
	localparam logic [5:0] RD = 6'h12;
	localparam logic [127:0] W1 = {32'h4444_0004, 32'h3333_0003, 32'h2222_0002, 32'h1111_0001};
	localparam logic [127:0] W2 = {32'h8888_0008, 32'h7777_0007, 32'h6666_0006, 32'h5555_0005};
	logic         core_clk = 0, link_clk = 0, rst = 1, pgood = 0, sus = 0, slow = 0;
	logic         cv = 0, cw = 0, rr = 0, crdy, rv, rto, mrn;
	logic [1:0]   pd = 0, crk = 0;
	logic [3:0]   cch = 0, mct, mcc;
	logic [5:0]   ca1 = 0, ca2 = 6'h2A;
	logic [7:0]   cke, sel;
	logic [23:0]  ca;
	logic [127:0] wd = 0, rd, dqi, dqo;
	logic [15:0]  dqoe, sti, sto, sci, sco, soe;
	int           checks = 0, bad_count = 0;

	always #10 core_clk = ~core_clk;
	initial begin
		#7;
		forever #80 link_clk = ~link_clk;
	end

	lpci_pin_if #(.RST_HOLD_CYC(20)) uut (.CORE_CLK_I(core_clk), .RESET_I(rst),
		.LINK_CLK_I(link_clk), .POWER_GOOD_I(pgood), .SUSPEND_TO_RAM_I(sus),
		.POWER_DOWN_RANK_I(pd), .CMD_VALID_I(cv), .CMD_READY_O(crdy), .CMD_WRITE_I(cw),
		.CMD_RANK_SEL_I(crk), .CMD_CHAN_SEL_I(cch), .CMD_CA_FIRST_I(ca1),
		.CMD_CA_SECOND_I(ca2), .CMD_WDATA_I(wd), .RD_VALID_O(rv), .RD_READY_I(rr),
		.RD_DATA_O(rd), .RD_TIMEOUT_O(rto), .MEM_RESET_N_O(mrn), .MEM_CLOCK_TRUE_O(mct),
		.MEM_CLOCK_COMP_O(mcc), .RANK_CLOCK_ENABLE_O(cke), .RANK_SELECT_O(sel),
		.CMD_ADDR_BUS_O(ca), .DATA_LANES_I(dqi), .DATA_LANES_O(dqo), .DATA_LANES_OE_O(dqoe),
		.STROBE_TRUE_I(sti), .STROBE_TRUE_O(sto), .STROBE_COMP_I(sci), .STROBE_COMP_O(sco),
		.STROBE_OE_O(soe));
	lpci_mem_model #(.RD_CODE(RD)) u_mem (.link_clk_i(link_clk), .slow_i(slow),
		.mem_clk_i(mct), .sel_i(sel), .ca_i(ca), .dq_i(dqo), .dq_oe_i(dqoe), .st_i(sto),
		.sc_i(sco), .s_oe_i(soe), .dq_o(dqi), .st_o(sti), .sc_o(sci));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic final_report();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic hang();
		bad_count++;
		final_report();
	endtask
	// Leaves valid high so back to back commands need no gap
	task automatic send(input logic w, input logic [1:0] rk, input logic [3:0] ch,
		input logic [127:0] d, output int n);
		{cw, crk, cch, ca1, wd, cv} = {w, rk, ch, w ? WR : RD, d, 1'b1};
		for (n = 0; n < 2000 && crdy !== 1'b1; n++) tick();
		if (n == 2000) hang();
		tick();
	endtask
	task automatic get(output logic [127:0] d, output logic t);
		int n;
		rr = 1'b1;
		for (n = 0; n < 2000 && rv !== 1'b1; n++) tick();
		if (n == 2000) hang();
		d = rd;
		t = rto;
		tick();
		rr = 1'b0;
		tick();
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		int n;
		chk({mrn, cke, sel, crdy}, 18'h0_0000);
		rst = 1'b0;
		pgood = 1'b1;
		for (n = 0; n < 400 && mrn !== 1'b1; n++) tick();
		if (n == 400) hang();
		chk(n >= 20, 1'b1);
		chk(cke, 8'h00);
		for (n = 0; n < 400 && crdy !== 1'b1; n++) tick();
		if (n == 400) hang();
		chk(cke, 8'hFF);
	endtask
	// Two writes, then two reads left waiting in the return buffer
	task automatic t_wr_rd();
		int n;
		logic [127:0] d;
		logic t;
		send(1'b1, 2'b01, 4'b0101, W1, n);
		send(1'b1, 2'b10, 4'b1010, W2, n);
		cv = 1'b0;
		for (n = 0; n < 400 && sel === 8'h00; n++) tick();
		if (n == 400) hang();
		chk({sel, ca}, {8'h11, 6'h00, WR, 6'h00, WR});
		send(1'b0, 2'b11, 4'hF, '0, n);
		send(1'b0, 2'b11, 4'hF, '0, n);
		cv = 1'b0;
		repeat (400) tick();
		for (int i = 0; i < 2; i++) begin
			get(d, t);
			chk({t, d}, {1'b0, W2[127:96], W1[95:64], W2[63:32], W1[31:0]});
		end
	endtask
	task automatic t_timeout();
		int n;
		logic [127:0] d;
		logic t;
		slow = 1'b1;
		send(1'b0, 2'b01, 4'b0001, '0, n);
		cv = 1'b0;
		get(d, t);
		chk(t, 1'b1);
		repeat (500) tick();
		slow = 1'b0;
	endtask
	// Ten writes at full rate must fill the eight word buffer and stall on ready
	task automatic t_fill();
		int n;
		int tot;
		logic [127:0] d;
		logic t;
		tot = 0;
		for (int i = 0; i < 10; i++) begin
			send(1'b1, 2'b01, 4'b0001, W1 + i, n);
			tot += n;
		end
		chk(tot > 0, 1'b1);
		send(1'b0, 2'b01, 4'b0001, '0, n);
		cv = 1'b0;
		get(d, t);
		chk({t, d[31:0]}, {1'b0, W1[31:0] + 32'h0000_0009});
	endtask
	task automatic t_pdown();
		pd = 2'b10;
		repeat (3) tick();
		chk(cke, 8'h55);
		pd = 2'b00;
		repeat (3) tick();
		chk(cke, 8'hFF);
	endtask
	task automatic t_suspend();
		int n;
		sus = 1'b1;
		repeat (2) tick();
		chk(crdy, 1'b0);
		for (n = 0; n < 400 && cke !== 8'h00; n++) tick();
		if (n == 400) hang();
		chk(cke, 8'h00);
		sus = 1'b0;
		for (n = 0; n < 400 && crdy !== 1'b1; n++) tick();
		if (n == 400) hang();
		chk({crdy, cke}, 9'h1FF);
	endtask

	initial begin
		repeat (16) tick();
		t_reset();
		t_wr_rd();
		t_timeout();
		t_fill();
		t_pdown();
		t_suspend();
		final_report();
	end
endmodule

`default_nettype wire
